// *** rtl/timer16_counter_input_capture.v ***
// Sixteen-bit timer counter with input capture, shared high byte and noise filter
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.vh"

// How it works
// - One shared eight-bit high-byte holding register serves all sixteen-bit registers.
// - Holding register keeps value; one high write serves many low writes.
// - Counter is sixteen bits; ticks increment, decrement or clear it.
// - Top output at sequence ceiling, bottom output when count is zero.
// - Counter high-byte address reaches only the holding register.
// - Count low read loads holding; low write loads full count at once.
// - Three tick-select bits choose tick source; zero stops the counter.
// - Counter readable and writable any time, running or stopped.
// - Processor write to counter beats clear, increment or decrement.
// - Four waveform mode bits split over control A and B set sequence.
// - Overflow flag set at mode-dependent point; may request interrupt.
// - Qualified capture edge copies full counter into capture register.
// - Capture flag set same cycle as copy; enable bit makes request.
// - Capture flag clears on service acknowledge or written one.
// - Capture low read copies high byte to holding; high read returns it.
// - Edge detector active except in capture-ceiling modes; filter always samples.
// - Capture pin synchronised like tick pin; filter adds four cycles.
// - Filter output changes only after four equal consecutive samples.
// - Filter enabled by control B bit, samples on system clock.
// - Driving the pin from software port output triggers a capture.
// - Each capture overwrites the capture register unconditionally.
module timer16_counter_input_capture
#(
   parameter PRESCALE_DIV = 8                     // Divide ratio for select code 2
)
(
   input  wire        clk,                        // System clock
   input  wire        resetn,                     // Asynchronous reset, active low
   input  wire [3:0]  reg_addr,                   // Register address
   input  wire [7:0]  reg_wdata,                  // Write data
   input  wire        reg_wr,                     // Write strobe
   input  wire        reg_rd,                     // Read strobe
   output reg  [7:0]  reg_rdata,                  // Read data, cycle after strobe
   input  wire        capture_input_pin,          // External capture pin
   input  wire        ext_tick_pin,               // External tick pin
   input  wire        capture_irq_ack,            // Capture interrupt serviced
   input  wire        overflow_irq_ack,           // Overflow interrupt serviced
   output reg         capture_irq,                // Capture interrupt request
   output reg         overflow_irq,               // Overflow interrupt request
   output reg         count_top,                  // Count at sequence ceiling
   output reg         count_bottom                // Count equals zero
);

////////////////////////////////////////////////////////////////////////////////
// Registers
// One holding byte serves every sixteen-bit register.
// An interrupt handler touching any of them between the two
// byte accesses of the main code corrupts that access;
// software must keep byte pairs atomic.
reg  [7:0]  control_reg_a;                        // Holds low mode bits
reg  [7:0]  control_reg_b;                        // Tick select, mode, edge, filter
reg  [7:0]  irq_mask_q;                           // Interrupt enables
reg  [7:0]  hold_q;                               // Shared high-byte holding register
reg  [15:0] count_value;                          // Counter
reg  [15:0] capture_value;                        // Capture register
reg  [15:0] compare_a_q;                          // Compare value A
reg  [15:0] compare_b_q;                          // Compare value B
reg         capture_flag;                         // Capture event flag
reg         overflow_flag;                        // Overflow event flag
reg         dir_down_q;                           // Counting downward
reg  [7:0]  presc_q;                              // Internal prescaler
reg  [1:0]  tick_sync_q;                          // Tick pin synchroniser
reg         tick_prev_q;                          // Tick pin previous level
reg  [1:0]  cap_sync_q;                           // Capture pin synchroniser
reg  [3:0]  cap_hist_q;                           // Filter sample history
reg         cap_filt_q;                           // Filter output
reg         cap_prev_q;                           // Edge detector previous level

wire [3:0]  waveform_mode_bits = {control_reg_b[`T16_B_WGM_HI], control_reg_a[`T16_A_WGM_LO]};
wire [2:0]  tick_source_select = control_reg_b[`T16_B_TICK_SEL];
wire        noise_filter_enable = control_reg_b[`T16_B_NOISE_EN];
wire        edge_rise = control_reg_b[`T16_B_EDGE_RISE];

////////////////////////////////////////////////////////////////////////////////
// Mode decode functions

// Ceiling of the count sequence for a given mode
function [15:0] top_of;
   input [3:0]  mode;
   input [15:0] cap;
   input [15:0] cmp;
   begin
      case (mode)
         4'h1, 4'h5:        top_of = 16'h00FF;
         4'h2, 4'h6:        top_of = 16'h01FF;
         4'h3, 4'h7:        top_of = 16'h03FF;
         4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp;
         4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
         default:           top_of = 16'hFFFF;
      endcase
   end
endfunction

// Capture register acts as ceiling in these modes
function uses_cap_top;
   input [3:0] mode;
   begin
      uses_cap_top = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC)
                     || (mode == 4'hE);
   end
endfunction

// Up-down modes turn at the ceiling and overflow at zero
function is_dual_slope;
   input [3:0] mode;
   begin
      is_dual_slope = (mode[1:0] != 2'b00 && !mode[2]) || (mode[3] && !mode[2]
                      && mode[1:0] != 2'b00) || mode == 4'h8 || mode == 4'h9;
   end
endfunction

// Clear-on-match modes
function is_ctc;
   input [3:0] mode;
   begin
      is_ctc = (mode == 4'h4) || (mode == 4'hC);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Tick generation
// Ceiling is recomputed every cycle from the live registers.
// Moving the ceiling below the count while running lets the
// counter run on to the full range before it wraps.
// External tick pin passes two flops before its edge detector.
wire [15:0] top_val  = top_of(waveform_mode_bits, capture_value, compare_a_q);
wire        at_top   = (count_value == top_val);
wire        at_bot   = (count_value == `T16_WORD_RESET);
wire        dual     = is_dual_slope(waveform_mode_bits);
wire        presc_hit = (presc_q == PRESCALE_DIV[7:0] - 8'h01);
wire        tick_rise = tick_sync_q[1] & ~tick_prev_q;
wire        tick_fall = ~tick_sync_q[1] & tick_prev_q;
reg         timer_tick;

always @*
begin
   case (tick_source_select)
      3'h0:    timer_tick = 1'b0;
      3'h1:    timer_tick = 1'b1;
      3'h2:    timer_tick = presc_hit;
      3'h6:    timer_tick = tick_fall;
      3'h7:    timer_tick = tick_rise;
      default: timer_tick = presc_hit;
   endcase
end

// Prescaler and tick pin synchroniser
always @(posedge clk or negedge resetn)
begin
   if (!resetn)
   begin
      presc_q     <= 8'h00;
      tick_sync_q <= 2'b00;
      tick_prev_q <= 1'b0;
   end
   else
   begin
      presc_q     <= presc_hit ? 8'h00 : presc_q + 8'h01;
      tick_sync_q <= {tick_sync_q[0], ext_tick_pin};
      tick_prev_q <= tick_sync_q[1];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Capture input path
// Same two-flop synchroniser as the tick pin.
// Filter output holds until four equal samples agree,
// so when enabled it adds four clocks of latency to every capture.
// Previous level and filter reset low, matching an idle pin,
// so no false edge follows reset.
wire        filt_in   = cap_sync_q[1];
wire [3:0]  hist_next = {cap_hist_q[2:0], filt_in};
wire        cap_level = noise_filter_enable ? cap_filt_q : filt_in;
wire        cap_active = !uses_cap_top(waveform_mode_bits);
wire        cap_event = cap_active && (edge_rise ? (cap_level & ~cap_prev_q)
                                                 : (~cap_level & cap_prev_q));

always @(posedge clk or negedge resetn)
begin
   if (!resetn)
   begin
      cap_sync_q <= 2'b00;
      cap_hist_q <= 4'h0;
      cap_filt_q <= 1'b0;
      cap_prev_q <= 1'b0;
   end
   else
   begin
      cap_sync_q <= {cap_sync_q[0], capture_input_pin};
      cap_hist_q <= hist_next;
      if (hist_next == 4'hF)
         cap_filt_q <= 1'b1;
      else if (hist_next == 4'h0)
         cap_filt_q <= 1'b0;
      if (cap_active)
         cap_prev_q <= cap_level;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Register access decode
// Low-byte accesses trigger the sixteen-bit transfer;
// high-byte accesses only reach the holding byte,
// except compare reads, which are direct.
wire wr_count_lo = reg_wr && reg_addr == `T16_COUNT_LOW;
wire wr_cap_lo   = reg_wr && reg_addr == `T16_CAPTURE_LOW;
wire rd_count_lo = reg_rd && reg_addr == `T16_COUNT_LOW;
wire rd_cap_lo   = reg_rd && reg_addr == `T16_CAPTURE_LOW;
wire wr_flags    = reg_wr && reg_addr == `T16_FLAGS;
wire any_hi_wr   = reg_wr && (reg_addr == `T16_COUNT_HIGH || reg_addr == `T16_CAPTURE_HIGH
                   || reg_addr == `T16_COMPARE_A_HIGH || reg_addr == `T16_COMPARE_B_HIGH);

////////////////////////////////////////////////////////////////////////////////
// Counter, capture, flags and register writes
always @(posedge clk or negedge resetn)
begin
   if (!resetn)
   begin
      control_reg_a <= `T16_CTRL_RESET;
      control_reg_b <= `T16_CTRL_RESET;
      irq_mask_q    <= `T16_CTRL_RESET;
      hold_q        <= 8'h00;
      count_value   <= `T16_WORD_RESET;
      capture_value <= `T16_WORD_RESET;
      compare_a_q   <= `T16_WORD_RESET;
      compare_b_q   <= `T16_WORD_RESET;
      capture_flag  <= 1'b0;
      overflow_flag <= 1'b0;
      dir_down_q    <= 1'b0;
   end
   else
   begin
      // Plain control writes
      if (reg_wr && reg_addr == `T16_CONTROL_A)
         control_reg_a <= reg_wdata;
      if (reg_wr && reg_addr == `T16_CONTROL_B)
         control_reg_b <= reg_wdata;
      if (reg_wr && reg_addr == `T16_IRQ_MASK)
         irq_mask_q <= reg_wdata;
      if (any_hi_wr)
         hold_q <= reg_wdata;
      // Count low read latches upper byte
      else if (rd_count_lo)
         hold_q <= count_value[15:8];
      // Capture low read latches upper byte
      else if (rd_cap_lo)
         hold_q <= capture_value[15:8];
      if (reg_wr && reg_addr == `T16_COMPARE_A_LOW)
         compare_a_q <= {hold_q, reg_wdata};
      if (reg_wr && reg_addr == `T16_COMPARE_B_LOW)
         compare_b_q <= {hold_q, reg_wdata};
      if (wr_count_lo)
         count_value <= {hold_q, reg_wdata};
      else if (timer_tick)
      begin
         if (dual)
         begin
            if (!dir_down_q && at_top)
            begin
               dir_down_q  <= 1'b1;
               count_value <= count_value - 16'h0001;
            end
            else if (dir_down_q && at_bot)
            begin
               dir_down_q  <= 1'b0;
               count_value <= count_value + 16'h0001;
            end
            else
               count_value <= dir_down_q ? count_value - 16'h0001
                                         : count_value + 16'h0001;
         end
         else if (at_top)
         begin
            dir_down_q  <= 1'b0;
            count_value <= `T16_WORD_RESET;
         end
         else
         begin
            dir_down_q  <= 1'b0;
            count_value <= count_value + 16'h0001;
         end
      end
      // Pin level includes software port drive
      if (cap_event)
         capture_value <= count_value;
      else if (wr_cap_lo && uses_cap_top(waveform_mode_bits))
         capture_value <= {hold_q, reg_wdata};
      // Cleared by ack or written one
      if (cap_event)
         capture_flag <= 1'b1;
      else if (capture_irq_ack || (wr_flags && reg_wdata[`T16_F_CAPTURE]))
         capture_flag <= 1'b0;
      if (timer_tick && !wr_count_lo && (dual ? (dir_down_q && at_bot)
          : (is_ctc(waveform_mode_bits) ? 1'b0 : at_top)))
         overflow_flag <= 1'b1;
      else if (overflow_irq_ack || (wr_flags && reg_wdata[`T16_F_OVERFLOW]))
         overflow_flag <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data and registered outputs
// Read data stand for one cycle only, zero otherwise.
// Requests and indications are registered, one cycle behind
// their flags and count, so every output comes from a flop.
// Unmapped addresses read as zero.
always @(posedge clk or negedge resetn)
begin
   if (!resetn)
   begin
      reg_rdata    <= 8'h00;
      capture_irq  <= 1'b0;
      overflow_irq <= 1'b0;
      count_top    <= 1'b0;
      count_bottom <= 1'b0;
   end
   else
   begin
      capture_irq  <= capture_flag & irq_mask_q[`T16_F_CAPTURE];
      overflow_irq <= overflow_flag & irq_mask_q[`T16_F_OVERFLOW];
      count_top    <= at_top;
      count_bottom <= at_bot;
      reg_rdata    <= 8'h00;
      if (reg_rd)
      begin
         case (reg_addr)
            `T16_CONTROL_A:      reg_rdata <= control_reg_a;
            `T16_CONTROL_B:      reg_rdata <= control_reg_b;
            `T16_COUNT_LOW:      reg_rdata <= count_value[7:0];
            `T16_CAPTURE_LOW:    reg_rdata <= capture_value[7:0];
            `T16_COMPARE_A_LOW:  reg_rdata <= compare_a_q[7:0];
            `T16_COMPARE_A_HIGH: reg_rdata <= compare_a_q[15:8];
            `T16_COMPARE_B_LOW:  reg_rdata <= compare_b_q[7:0];
            `T16_COMPARE_B_HIGH: reg_rdata <= compare_b_q[15:8];
            `T16_COUNT_HIGH,
            `T16_CAPTURE_HIGH:   reg_rdata <= hold_q;
            `T16_FLAGS:          reg_rdata <= {2'b00, capture_flag, 4'h0, overflow_flag};
            `T16_IRQ_MASK:       reg_rdata <= irq_mask_q;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end
end

endmodule // timer16_counter_input_capture
`default_nettype wire

// *** rtl/timer16_map.vh ***
// Register offsets, field positions and timing constants of the 16-bit timer
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// Register offsets on the 8-bit register port
`define T16_CONTROL_A      4'h0
`define T16_CONTROL_B      4'h1
`define T16_COUNT_LOW      4'h2
`define T16_COUNT_HIGH     4'h3
`define T16_CAPTURE_LOW    4'h4
`define T16_CAPTURE_HIGH   4'h5
`define T16_COMPARE_A_LOW  4'h6
`define T16_COMPARE_A_HIGH 4'h7
`define T16_COMPARE_B_LOW  4'h8
`define T16_COMPARE_B_HIGH 4'h9
`define T16_FLAGS          4'hA
`define T16_IRQ_MASK       4'hB
// Control register A fields
`define T16_A_WGM_LO       1:0
// Control register B fields
`define T16_B_TICK_SEL     2:0
`define T16_B_WGM_HI       4:3
`define T16_B_EDGE_RISE    6
`define T16_B_NOISE_EN     7
// Flag and mask bit positions
`define T16_F_OVERFLOW     0
`define T16_F_CAPTURE      5
// Reset values
`define T16_CTRL_RESET     8'h00
`define T16_WORD_RESET     16'h0000
// Filter depth in system clock samples
`define T16_FILTER_DEPTH   4
`endif

// *** dv/timer16_monitor.sv ***
// Port-level assertion checker for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
module timer16_monitor
#(
   parameter PRESCALE_DIV = 8                 // Tick divide ratio
)
(
   input wire logic       clk,                // Clock
   input wire logic       resetn,             // Reset, low
   input wire logic [3:0] reg_addr,           // Address
   input wire logic [7:0] reg_wdata,          // Write data
   input wire logic       reg_wr,             // Write strobe
   input wire logic       reg_rd,             // Read strobe
   input wire logic [7:0] reg_rdata,          // Read data
   input wire logic       capture_input_pin,  // Capture pin
   input wire logic       ext_tick_pin,       // Tick pin
   input wire logic       capture_irq_ack,    // Capture service
   input wire logic       overflow_irq_ack,   // Overflow service
   input wire logic       capture_irq,        // Capture request
   input wire logic       overflow_irq,       // Overflow request
   input wire logic       count_top,          // At ceiling
   input wire logic       count_bottom        // At zero
);
   logic [7:0] hold_q, ctl_a_q, ctl_b_q, mask_q;
   logic       hold_v_q;
   logic       ceil, cap_ok;
   // Capture enabled on rising edges outside ceiling modes
   assign ceil = ctl_b_q[4] && !ctl_a_q[0];
   assign cap_ok = mask_q[5] && ctl_b_q[6] && !ceil;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of settings and shared high byte
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         hold_q <= 8'h00;
         hold_v_q <= 1'b1;
         ctl_a_q <= 8'h00;
         ctl_b_q <= 8'h00;
         mask_q <= 8'h00;
      end
      else
      begin
         if (reg_wr && reg_addr == 4'h0) ctl_a_q <= reg_wdata;
         if (reg_wr && reg_addr == 4'h1) ctl_b_q <= reg_wdata;
         if (reg_wr && reg_addr == 4'hB) mask_q <= reg_wdata;
         if (reg_wr && reg_addr[0] && reg_addr >= 4'h3 && reg_addr <= 4'h9)
         begin
            hold_q <= reg_wdata;
            hold_v_q <= 1'b1;
         end
         if (reg_rd && (reg_addr == 4'h2 || reg_addr == 4'h4)) hold_v_q <= 1'b0;
      end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_HOLD_READ: assert property (reg_rd && reg_addr inside {4'h3, 4'h5} && hold_v_q
      |=> reg_rdata == $past(hold_q)) else $error("High byte read not from holding");
   AST_RESET_OUT: assert property (!$past(resetn) |-> !capture_irq && !overflow_irq
      && !count_top && reg_rdata == 8'h00) else $error("Outputs not clear after reset");
   AST_STOPPED: assert property (ctl_b_q[2:0] == 3'h0 && $past(ctl_b_q[2:0]) == 3'h0
      && !reg_wr && !$past(reg_wr) && count_bottom |=> count_bottom)
      else $error("Stopped counter moved");
   AST_CAP_EDGE: assert property (!ctl_b_q[7] && cap_ok && !capture_irq
      && $rose(capture_input_pin) |-> ##[2:6] capture_irq) else $error("Edge not captured");
   AST_CAP_FILT: assert property ((ctl_b_q[7] && cap_ok && !capture_irq
      && $rose(capture_input_pin)) ##1 capture_input_pin[*5] |-> ##[0:6] capture_irq)
      else $error("Filtered edge not captured");
   AST_GLITCH: assert property ((ctl_b_q[7] && cap_ok && !capture_irq
      && $rose(capture_input_pin)) ##1 capture_input_pin ##1 !capture_input_pin[*8]
      |-> !capture_irq) else $error("Short pulse passed filter");
   AST_CEIL: assert property (mask_q[5] && ceil && !capture_irq
      && $changed(capture_input_pin) |-> !capture_irq[*8]) else $error("Capture in ceiling mode");
   AST_MASK: assert property (!mask_q[5] && !(reg_wr && reg_addr == 4'hB)
      |=> !capture_irq) else $error("Masked capture request");
   AST_CAP_ACK: assert property (capture_irq && capture_irq_ack
      |-> ##[1:2] !capture_irq) else $error("Capture request kept after service");
   AST_OVF_ACK: assert property (overflow_irq && overflow_irq_ack
      |-> ##[1:2] !overflow_irq) else $error("Overflow request kept after service");
   COV_CAP: cover property ($rose(capture_irq));
   COV_OVF: cover property ($rose(overflow_irq));
   COV_TOP: cover property (count_top);
endmodule // timer16_monitor
bind timer16_counter_input_capture timer16_monitor #(.PRESCALE_DIV(PRESCALE_DIV)) u_mon
(
   .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .capture_input_pin(capture_input_pin), .ext_tick_pin(ext_tick_pin),
   .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
   .capture_irq(capture_irq), .overflow_irq(overflow_irq),
   .count_top(count_top), .count_bottom(count_bottom)
);
`default_nettype wire

// *** dv/cpu_model.sv ***
// Processor core model driving the 8-bit register port
`timescale 1ns/1ps
`default_nettype none
module cpu_model
(
   input  wire logic       clk,        // Clock
   input  wire logic [7:0] reg_rdata,  // Read data
   output logic      [3:0] reg_addr,   // Address
   output logic      [7:0] reg_wdata,  // Write data
   output logic            reg_wr,     // Write strobe
   output logic            reg_rd      // Read strobe
);
   // Idle bus at time zero
   initial
   begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One write cycle, then scrambled address and data
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // One read cycle, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge clk);
      d = reg_rdata;
   endtask
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr(lo + 4'h1, v[15:8]);
      wr(lo, v[7:0]);
   endtask
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 4'h1, v[15:8]);
   endtask
endmodule // cpu_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the 16-bit timer with input capture
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Bench signals and bookkeeping
   logic clk, resetn, reg_wr, reg_rd, pin, cap_ack, ovf_ack, tick_pin;
   logic cap_irq, ovf_irq, top, bottom, top_seen;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, b;
   logic [15:0] v;
   int bad_count, compares, n, n0, n1;
   ////////////////////////////////////////////////////////////////////////////////
   timer16_counter_input_capture #(.PRESCALE_DIV(8)) dut
   (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .capture_input_pin(pin), .ext_tick_pin(tick_pin), .capture_irq_ack(cap_ack),
      .overflow_irq_ack(ovf_ack), .capture_irq(cap_irq), .overflow_irq(ovf_irq),
      .count_top(top), .count_bottom(bottom)
   );
   cpu_model cpu
   (
      .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Port drive of the capture pin
   task automatic set_pin(input logic x);
      @(posedge clk);
      pin <= x;
   endtask
   task automatic ack_cap();
      @(posedge clk);
      cap_ack <= 1'b1;
      @(posedge clk);
      cap_ack <= 1'b0;
   endtask
   task automatic wait_irq(output int k);
      k = 0;
      while (cap_irq !== 1'b1 && k < 30)
      begin
         @(negedge clk);
         k++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cpu.rd16(4'h2, v); check(v, 16'h0000);
      cpu.rd16(4'h4, v); check(v, 16'h0000);
      cpu.rd(4'hA, b); check({8'h00, b}, 16'h0000);
      cpu.rd(4'hF, b); check({8'h00, b}, 16'h0000);
   endtask
   task automatic t_hold();
      cpu.wr16(4'h2, 16'h01FF);
      cpu.wr(4'h6, 8'h34);
      cpu.rd(4'h7, b); check({8'h00, b}, 16'h0001);
      cpu.rd16(4'h2, v); check(v, 16'h01FF);
      cpu.wr(4'h3, 8'h5A);
      cpu.rd(4'h3, b); check({8'h00, b}, 16'h005A);
      cpu.rd16(4'h2, v); check(v, 16'h01FF);
   endtask
   task automatic t_count();
      cpu.wr16(4'h2, 16'hFFF0);
      cpu.wr(4'hB, 8'h01);
      cpu.wr(4'h1, 8'h01);
      n = 0;
      top_seen = 1'b0;
      while (ovf_irq !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         top_seen |= top;
         n++;
      end
      check({15'h0, ovf_irq}, 16'h0001);
      check({15'h0, top_seen}, 16'h0001);
      cpu.rd(4'hA, b); check({8'h00, b & 8'h01}, 16'h0001);
      @(posedge clk);
      ovf_ack <= 1'b1;
      @(posedge clk);
      ovf_ack <= 1'b0;
      cyc(3); check({15'h0, ovf_irq}, 16'h0000);
      cpu.wr16(4'h2, 16'h4000);
      cpu.wr(4'h1, 8'h00);
      cpu.rd16(4'h2, v); check({15'h0, v >= 16'h4000 && v <= 16'h4003}, 16'h0001);
      cpu.wr16(4'h2, 16'h0000);
      cyc(6); check({15'h0, bottom}, 16'h0001);
      cpu.rd16(4'h2, v); check(v, 16'h0000);
      // Three rising edges on the external tick pin
      cpu.wr(4'h1, 8'h07);
      repeat (3)
      begin
         @(posedge clk);
         tick_pin <= 1'b1;
         @(posedge clk);
         tick_pin <= 1'b0;
      end
      cyc(4);
      cpu.wr(4'h1, 8'h00);
      cpu.rd16(4'h2, v); check(v, 16'h0003);
   endtask
   task automatic t_capture();
      cpu.wr16(4'h2, 16'h1234);
      cpu.wr(4'hB, 8'h00);
      set_pin(1'b1);
      cyc(8); cpu.rd(4'hA, b); check({8'h00, b & 8'h20}, 16'h0000);
      set_pin(1'b0);
      cyc(8); cpu.rd(4'hA, b); check({8'h00, b & 8'h20}, 16'h0020);
      check({15'h0, cap_irq}, 16'h0000);
      cpu.wr(4'hB, 8'h20);
      cyc(3); check({15'h0, cap_irq}, 16'h0001);
      cpu.rd16(4'h4, v); check(v, 16'h1234);
      cpu.wr(4'h1, 8'h40);
      cpu.wr(4'hA, 8'h20);
      cyc(3); check({15'h0, cap_irq}, 16'h0000);
      cpu.wr16(4'h2, 16'h5678);
      set_pin(1'b1);
      wait_irq(n0); check({15'h0, cap_irq}, 16'h0001);
      cpu.wr16(4'h2, 16'h9ABC);
      set_pin(1'b0);
      cyc(4); set_pin(1'b1);
      cyc(8); cpu.rd16(4'h4, v); check(v, 16'h9ABC);
      ack_cap();
      cyc(3); check({15'h0, cap_irq}, 16'h0000);
   endtask
   task automatic t_filter();
      set_pin(1'b0);
      cpu.wr(4'h1, 8'hC0);
      cyc(10); set_pin(1'b1);
      set_pin(1'b1);
      set_pin(1'b0);
      cyc(14); check({15'h0, cap_irq}, 16'h0000);
      set_pin(1'b1);
      wait_irq(n1); check({15'h0, cap_irq}, 16'h0001);
      check(16'(n1 - n0), 16'h0004);
      ack_cap();
   endtask
   task automatic t_ceiling();
      cpu.wr(4'h1, 8'h18);
      cpu.wr(4'h0, 8'h00);
      cpu.wr16(4'h4, 16'h03E8);
      set_pin(1'b0);
      cyc(10); check({15'h0, cap_irq}, 16'h0000);
      cpu.rd16(4'h4, v); check(v, 16'h03E8);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Clock generator
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog against a hang
   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      pin = 1'b0;
      tick_pin = 1'b0;
      cap_ack = 1'b0;
      ovf_ack = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_hold();
      t_count();
      t_capture();
      t_filter();
      t_ceiling();
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
